// *** rop_regs.svh ***
// Record layer constants shared by both link ends.
// Assumes inclusion by the package only; no logic lives here.
`ifndef ROP_REGS_SVH
`define ROP_REGS_SVH
`define ROP_PAD_OP 8'h00
`define ROP_TW_OP 8'hFF
`define ROP_ERR_OP 8'hFA
`define ROP_FRAME_DATA 2'b01
`define ROP_TW_SIZE 7'h04
`define ROP_KEY_BYTES 7'h50
`define ROP_DESC_W 19
`define ROP_DESC_RST 19'h00000
`define ROP_D_SIZE 6:0
`define ROP_D_VALID 7
`define ROP_D_MODE 8
`define ROP_D_INSTR 18:9
`define ROP_ST_IDX 7
`define ROP_ST_AD 6
`endif

// *** rop_pkg.sv ***
// Types shared by the record layer ends.
// Assumes rop_regs.svh is on the include path.
package rop_pkg;
	`include "rop_regs.svh"
	// One record descriptor table entry
	typedef logic [`ROP_DESC_W-1:0] desc_t;
	// Byte parser phase, Gray coded along op, seq, data
	typedef enum logic [1:0] {
		PH_OP = 2'b00,
		PH_SEQ = 2'b01,
		PH_DAT = 2'b11,
		PH_PAD = 2'b10
	} ph_e;
endpackage

// *** rop_link_if.sv ***
// Link carrying 64-bit data words both ways between the two ends.
// Assumes both ends share ref_clk; the testbench instantiates it.
`timescale 1ns/1ps
`default_nettype none
interface rop_link_if (input wire logic ref_clk);
	// Host to device request words
	logic req_valid;
	logic req_ready;
	logic [1:0] req_frame;
	logic [63:0] req_data;
	logic req_eop;
	// Device to host reply words
	logic rsp_valid;
	logic rsp_ready;
	logic [1:0] rsp_frame;
	logic [63:0] rsp_data;
	logic rsp_eop;
	modport dev (
		input req_valid, req_frame, req_data, req_eop, rsp_ready,
		output req_ready, rsp_valid, rsp_frame, rsp_data, rsp_eop
	);
	modport host (
		output req_valid, req_frame, req_data, req_eop, rsp_ready,
		input req_ready, rsp_valid, rsp_frame, rsp_data, rsp_eop
	);
endinterface
`default_nettype wire

// *** rop_dev_end.sv ***
// Device end of the record packing layer: unpacks request records,
// tracks them, and packs core replies into reply packets.
// Assumes core replies arrive in request order on the same clock.
`timescale 1ns/1ps
`default_nettype none
module rop_dev_end import rop_pkg::*; #(
	parameter int TRK_AW = 4,
	parameter int MAX_WORDS = 8
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	rop_link_if.dev lnk,
	output logic rec_valid,
	input wire logic rec_ready,
	output logic [7:0] rec_opcode,
	output logic [15:0] rec_seq,
	output logic [9:0] rec_instr,
	output logic rec_mode,
	output logic [6:0] rec_len,
	output logic [639:0] rec_key,
	input wire logic cr_valid,
	output logic cr_ready,
	input wire logic [15:0] cr_seq,
	input wire logic [7:0] cr_status,
	input wire logic [23:0] cr_index,
	input wire logic [63:0] cr_ad,
	input wire logic cr_has_idx,
	input wire logic cr_has_ad
);
	typedef struct packed {
		logic [63:0] w;
		logic [3:0] nb;
		logic eop;
		ph_e ph;
		logic sh;
		logic mid;
		logic [15:0] seq;
		logic [6:0] cnt;
		logic [7:0] opc;
		logic [639:0] dat;
		logic [6:0] len;
		logic ov;
		logic [7:0] oopc;
		logic [15:0] oseq;
		logic [639:0] okey;
		logic [6:0] olen;
		logic [9:0] oins;
		logic omode;
		logic twv;
		logic [7:0] twi;
		desc_t twd;
		logic [TRK_AW:0] wp;
		logic [TRK_AW:0] rp;
		logic [119:0] rb;
		logic [3:0] rn;
		logic po;
		logic [15:0] ps;
		logic [63:0] pw;
		logic [3:0] pn;
		logic [7:0] pc;
		logic [1:0][64:0] fb;
		logic [1:0] fc;
	} dev_s;

	dev_s q, n;
	desc_t tbl [256];
	logic [24:0] trk [2**TRK_AW];
	logic push;
	logic [24:0] pushd;

	// Descriptor table and reply tracking memories
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < 256; i++) begin
				tbl[i] <= `ROP_DESC_RST;
			end
		end else if (q.twv) begin
			tbl[q.twi] <= q.twd;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (push) begin
			trk[q.wp[TRK_AW-1:0]] <= pushd;
		end
	end

	// Receive extractor, tracking queue and reply packer
	always_comb begin
		logic stop;
		logic fin;
		logic full;
		logic [7:0] b;
		desc_t e;
		logic [24:0] hd;
		logic ne, htw, perr, avail, can;
		logic [15:0] rs;
		logic [7:0] st, ropc;
		logic [95:0] body;
		logic [3:0] bl;
		n = q;
		stop = 1'b0;
		fin = 1'b0;
		full = 1'b0;
		b = 8'h00;
		e = '0;
		push = 1'b0;
		pushd = '0;
		cr_ready = 1'b0;
		n.twv = 1'b0;
		if (q.ov && rec_ready) begin
			n.ov = 1'b0;
		end
		// Words without data framing are dropped
		if (q.nb == 4'd0 && lnk.req_valid) begin
			n.w = lnk.req_data;
			n.nb = (lnk.req_frame == `ROP_FRAME_DATA) ? 4'd8 : 4'd0;
			n.eop = lnk.req_eop;
		end
		// Walk the lanes; stop after one record so output keeps up
		for (int k = 0; k < 8; k++) begin
			full = (n.wp[TRK_AW] != n.rp[TRK_AW]) &&
				(n.wp[TRK_AW-1:0] == n.rp[TRK_AW-1:0]);
			fin = 1'b0;
			if (n.nb != 4'd0 && !stop && !n.ov && !full) begin
				b = n.w[63:56];
				n.w = {n.w[55:0], 8'h00};
				n.nb = n.nb - 4'd1;
				case (n.ph)
				PH_OP: begin
					if (b == `ROP_PAD_OP) begin
						n.ph = PH_PAD;
					end else begin
						e = tbl[b];
						n.opc = b;
						n.len = (b == `ROP_TW_OP) ? `ROP_TW_SIZE : e[`ROP_D_SIZE];
						n.cnt = n.len;
						if (b != `ROP_TW_OP && !e[`ROP_D_VALID]) begin
							n.ph = PH_PAD;
						end else if (!n.mid) begin
							n.ph = PH_SEQ;
							n.sh = 1'b0;
						end else begin
							n.seq = n.seq + 16'd1;
							n.ph = PH_DAT;
							fin = (n.len == 7'd0);
						end
					end
				end
				PH_SEQ: begin
					n.seq = {n.seq[7:0], b};
					if (n.sh) begin
						n.ph = PH_DAT;
						fin = (n.cnt == 7'd0);
					end else begin
						n.sh = 1'b1;
					end
				end
				PH_DAT: begin
					n.dat = {n.dat[631:0], b};
					n.cnt = n.cnt - 7'd1;
					fin = (n.cnt == 7'd0);
				end
				PH_PAD: begin
				end
				default: n.ph = PH_PAD;
				endcase
				if (fin) begin
					stop = 1'b1;
					n.ph = PH_OP;
					n.mid = 1'b1;
					push = 1'b1;
					pushd = {^{n.opc, n.seq}, n.opc, n.seq};
					n.wp = n.wp + 1'b1;
					e = tbl[n.opc];
					if (n.opc == `ROP_TW_OP) begin
						n.twv = 1'b1;
						n.twi = n.dat[31:24];
						n.twd = n.dat[18:0];
					end else begin
						n.ov = 1'b1;
						n.oopc = n.opc;
						n.oseq = n.seq;
						n.olen = n.len;
						n.oins = e[`ROP_D_INSTR];
						n.omode = e[`ROP_D_MODE];
						n.okey = n.dat << {`ROP_KEY_BYTES - n.len, 3'b000};
					end
				end
				if (n.nb == 4'd0 && n.eop) begin
					n.ph = PH_OP;
					n.mid = 1'b0;
				end
			end
		end
		// Two-entry output buffer drains toward the link
		if (q.fc != 2'd0 && lnk.rsp_ready) begin
			n.fb[0] = q.fb[1];
			n.fb[1] = '0;
			n.fc = q.fc - 2'd1;
		end
		can = (n.fc != 2'd2);
		hd = trk[q.rp[TRK_AW-1:0]];
		ne = (q.wp != q.rp);
		htw = (hd[23:16] == `ROP_TW_OP);
		perr = ^hd;
		avail = ne && (htw || cr_valid);
		rs = (htw || perr) ? hd[15:0] : cr_seq;
		st = {cr_has_idx, cr_has_ad, cr_status[5:0]};
		ropc = perr ? `ROP_ERR_OP : hd[23:16];
		body = '0;
		bl = 4'd1;
		if (perr) begin
			body = {8'h01, 40'h0, hd[15:0], 32'h0};
			bl = 4'd8;
		end else if (!htw) begin
			// Reply body built from status, index and associated data
			case ({cr_has_idx, cr_has_ad})
			2'b11: begin
				body = {st, cr_index, cr_ad};
				bl = 4'd12;
			end
			2'b10: begin
				body = {st, cr_index, 64'h0};
				bl = 4'd4;
			end
			2'b01: begin
				body = {st, cr_ad, 24'h0};
				bl = 4'd9;
			end
			default: body = {st, 88'h0};
			endcase
		end
		// Packer: shift record bytes, close, or start a record
		if (q.rn != 4'd0) begin
			if (q.pn == 4'd8) begin
				if (can) begin
					n.fb[n.fc[0]] = {1'b0, q.pw};
					n.fc = n.fc + 2'd1;
					n.pw = '0;
					n.pn = 4'd0;
					n.pc = q.pc + 8'd1;
				end
			end else begin
				n.pw = q.pw | ({56'h0, q.rb[119:112]} << {3'd7 - q.pn[2:0], 3'b000});
				n.rb = {q.rb[111:0], 8'h00};
				n.rn = q.rn - 4'd1;
				n.pn = q.pn + 4'd1;
			end
		end else if (q.po && can && (!avail || rs != q.ps ||
				q.pc >= 8'(MAX_WORDS - 3))) begin
			// Idle, full or out of sequence: pad and end packet.
			// A record of up to 15 bytes may flush two more words, so
			// room for two plus the closing word is kept in hand.
			n.fb[n.fc[0]] = {1'b1, q.pw};
			n.fc = n.fc + 2'd1;
			n.po = 1'b0;
			n.pw = '0;
			n.pn = 4'd0;
			n.pc = 8'd0;
		end else if (avail) begin
			cr_ready = !htw;
			if (!q.po) begin
				n.rb = {ropc, rs, body};
				n.rn = bl + 4'd3;
			end else begin
				n.rb = {ropc, body, 16'h0};
				n.rn = bl + 4'd1;
			end
			n.po = 1'b1;
			n.ps = rs + 16'd1;
			n.rp = q.rp + 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	// Link and user outputs, all from flops except handshakes
	assign lnk.req_ready = (q.nb == 4'd0);
	assign lnk.rsp_valid = (q.fc != 2'd0);
	assign lnk.rsp_frame = `ROP_FRAME_DATA;
	assign lnk.rsp_data = q.fb[0][63:0];
	assign lnk.rsp_eop = q.fb[0][64];
	assign rec_valid = q.ov;
	assign rec_opcode = q.oopc;
	assign rec_seq = q.oseq;
	assign rec_instr = q.oins;
	assign rec_mode = q.omode;
	assign rec_len = q.olen;
	assign rec_key = q.okey;
endmodule
`default_nettype wire

// *** rop_host_end.sv ***
// Host end: packs request records into link packets and parses
// reply records. Assumes the device end shares ref_clk.
`timescale 1ns/1ps
`default_nettype none
module rop_host_end import rop_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst_b,
	rop_link_if.host lnk,
	input wire logic rq_valid,
	output logic rq_ready,
	input wire logic [7:0] rq_opcode,
	input wire logic [639:0] rq_key,
	input wire logic rq_last,
	output logic rp_valid,
	output logic [7:0] rp_opcode,
	output logic [15:0] rp_seq,
	output logic rp_error,
	output logic [95:0] rp_data,
	output logic [3:0] rp_len
);
	typedef struct packed {
		logic [663:0] sr;
		logic [6:0] sn;
		logic po;
		logic [15:0] seq;
		logic [63:0] w;
		logic [3:0] wn;
		logic last;
		logic wtw;
		logic ov;
		logic oeop;
		logic [63:0] ow;
		logic [63:0] rw;
		logic [3:0] rn;
		logic reop;
		ph_e ph;
		logic sh;
		logic mid;
		logic hs;
		logic [15:0] rseq;
		logic [7:0] ropc;
		logic [3:0] bc;
		logic [95:0] rb;
		logic [3:0] rl;
		logic pv;
		logic [7:0] popc;
		logic [15:0] pseq;
		logic [95:0] pdat;
		logic [3:0] plen;
	} host_s;

	host_s q, n;
	desc_t tbl [256];
	logic ld;

	// Local copy of the descriptor table, written as it is sent
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < 256; i++) begin
				tbl[i] <= `ROP_DESC_RST;
			end
		end else if (ld && rq_opcode == `ROP_TW_OP) begin
			tbl[rq_key[639:632]] <= rq_key[626:608];
		end
	end

	// Everything else stalls while a table write is unanswered
	assign rq_ready = (q.sn == 7'd0) && !q.wtw && !(q.po && q.last);
	assign ld = rq_valid && rq_ready;

	always_comb begin
		logic [7:0] b;
		logic [3:0] nbc;
		logic [6:0] len;
		desc_t e;
		n = q;
		b = 8'h00;
		nbc = 4'd0;
		e = tbl[rq_opcode];
		len = (rq_opcode == `ROP_TW_OP) ? `ROP_TW_SIZE : e[`ROP_D_SIZE];
		n.pv = 1'b0;
		if (q.ov && lnk.req_ready) begin
			n.ov = 1'b0;
		end
		// Transmit: one byte per clock into the current word
		if (q.sn != 7'd0) begin
			if (q.wn == 4'd8) begin
				if (!n.ov) begin
					n.ow = q.w;
					n.oeop = 1'b0;
					n.ov = 1'b1;
					n.w = '0;
					n.wn = 4'd0;
				end
			end else begin
				n.w = q.w | ({56'h0, q.sr[663:656]} << {3'd7 - q.wn[2:0], 3'b000});
				n.sr = {q.sr[655:0], 8'h00};
				n.sn = q.sn - 7'd1;
				n.wn = q.wn + 4'd1;
			end
		end else if (q.po && !n.ov && (q.last || !rq_valid)) begin
			n.ow = q.w;
			n.oeop = 1'b1;
			n.ov = 1'b1;
			n.po = 1'b0;
			n.last = 1'b0;
			n.w = '0;
			n.wn = 4'd0;
		end else if (ld) begin
			if (!q.po) begin
				n.sr = {rq_opcode, q.seq, rq_key};
				n.sn = len + 7'd3;
			end else begin
				n.sr = {rq_opcode, rq_key, 16'h0};
				n.sn = len + 7'd1;
			end
			n.seq = q.seq + 16'd1;
			n.po = 1'b1;
			n.last = rq_last;
			n.wtw = (rq_opcode == `ROP_TW_OP);
		end
		// Receive: parse one reply byte per clock
		if (q.rn == 4'd0) begin
			if (lnk.rsp_valid) begin
				n.rw = lnk.rsp_data;
				n.rn = (lnk.rsp_frame == `ROP_FRAME_DATA) ? 4'd8 : 4'd0;
				n.reop = lnk.rsp_eop;
			end
		end else begin
			b = q.rw[63:56];
			n.rw = {q.rw[55:0], 8'h00};
			n.rn = q.rn - 4'd1;
			case (q.ph)
			PH_OP: begin
				if (b == `ROP_PAD_OP) begin
					n.ph = PH_PAD;
				end else begin
					n.ropc = b;
					n.rb = '0;
					n.rl = 4'd0;
					n.hs = 1'b0;
					n.mid = 1'b1;
					if (!q.mid) begin
						n.ph = PH_SEQ;
						n.sh = 1'b0;
					end else begin
						n.rseq = q.rseq + 16'd1;
						n.ph = PH_DAT;
					end
				end
			end
			PH_SEQ: begin
				n.rseq = {q.rseq[7:0], b};
				n.sh = 1'b1;
				if (q.sh) begin
					n.ph = PH_DAT;
				end
			end
			PH_DAT: begin
				n.rb = {q.rb[87:0], b};
				n.rl = q.rl + 4'd1;
				if (!q.hs) begin
					// First body byte decides the record length
					n.hs = 1'b1;
					if (q.ropc == `ROP_ERR_OP) begin
						nbc = 4'd7;
					end else if (q.ropc == `ROP_TW_OP) begin
						nbc = 4'd0;
					end else begin
						nbc = (b[`ROP_ST_IDX] ? 4'd3 : 4'd0) +
							(b[`ROP_ST_AD] ? 4'd8 : 4'd0);
					end
				end else begin
					nbc = q.bc - 4'd1;
				end
				n.bc = nbc;
				if (nbc == 4'd0) begin
					n.ph = PH_OP;
					n.pv = 1'b1;
					n.popc = q.ropc;
					n.pseq = q.rseq;
					n.pdat = n.rb;
					n.plen = n.rl;
					if (q.ropc == `ROP_TW_OP) begin
						n.wtw = 1'b0;
					end
				end
			end
			PH_PAD: begin
			end
			default: n.ph = PH_PAD;
			endcase
			if (n.rn == 4'd0 && q.reop) begin
				n.ph = PH_OP;
				n.mid = 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign lnk.req_valid = q.ov;
	assign lnk.req_frame = `ROP_FRAME_DATA;
	assign lnk.req_data = q.ow;
	assign lnk.req_eop = q.oeop;
	assign lnk.rsp_ready = (q.rn == 4'd0);
	assign rp_valid = q.pv;
	assign rp_opcode = q.popc;
	assign rp_seq = q.pseq;
	assign rp_error = (q.popc == `ROP_ERR_OP);
	assign rp_data = q.pdat;
	assign rp_len = q.plen;
endmodule
`default_nettype wire

// *** rop_link_chk.sv ***
// Checker for both directions of the record link.
// Assumes one clock; tb instantiates it beside the link interface.
`timescale 1ns/1ps
`default_nettype none
module rop_link_chk #(
	parameter int MAX_WORDS = 8
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic [1:0] req_frame,
	input wire logic [63:0] req_data,
	input wire logic req_eop,
	input wire logic rsp_valid,
	input wire logic rsp_ready,
	input wire logic [1:0] rsp_frame,
	input wire logic [63:0] rsp_data,
	input wire logic rsp_eop
);
	logic req_sop_q;
	logic rsp_sop_q;
	logic [7:0] rsp_cnt_q;
	// Packet start flags and reply word count, so opcode lanes are known
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			req_sop_q <= 1'b1;
			rsp_sop_q <= 1'b1;
			rsp_cnt_q <= 8'h00;
		end else begin
			if (req_valid && req_ready)
				req_sop_q <= req_eop;
			if (rsp_valid && rsp_ready) begin
				rsp_sop_q <= rsp_eop;
				rsp_cnt_q <= rsp_eop ? 8'h00 : rsp_cnt_q + 8'h01;
			end
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	a_req_frame_ok: assert property (req_valid |-> req_frame == 2'b01)
		else $error("request word not framed as data");
	a_rsp_frame_ok: assert property (rsp_valid |-> rsp_frame == 2'b01)
		else $error("reply word not framed as data");
	a_req_hold_stall: assert property (req_valid && !req_ready |=>
		req_valid && $stable(req_data) && $stable(req_eop))
		else $error("request word changed while stalled");
	a_rsp_hold_stall: assert property (rsp_valid && !rsp_ready |=>
		rsp_valid && $stable(rsp_data) && $stable(rsp_eop))
		else $error("reply word changed while stalled");
	a_req_no_lead: assert property (req_valid && req_sop_q |->
		req_data[63:56] != 8'h00)
		else $error("request packet starts with padding");
	a_rsp_no_lead: assert property (rsp_valid && rsp_sop_q |->
		rsp_data[63:56] != 8'h00)
		else $error("reply packet starts with padding");
	a_rsp_pkt_len: assert property (rsp_valid |-> rsp_cnt_q < MAX_WORDS)
		else $error("reply packet too long");
	a_req_taken_soon: assert property (req_valid |-> ##[0:1000] req_ready)
		else $error("request word never taken");
	c_req_pkt: cover property (req_valid && req_ready && req_eop);
	c_rsp_pkt: cover property (rsp_valid && rsp_ready && rsp_eop);
	c_req_stall: cover property (req_valid && !req_ready);
endmodule
`default_nettype wire

// *** tb.sv ***
// Testbench joining host end and device end over the record link.
// Assumes the package and interface are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb import rop_pkg::*; ;
	typedef struct packed {logic [7:0] op; logic [15:0] seq;} trk_s;
	logic ref_clk = 1'b0;
	logic rst_b, rq_valid, rq_ready, rq_last, rp_valid, rp_error;
	logic [7:0] rq_opcode, rp_opcode, rec_opcode, cr_status;
	logic [639:0] rq_key, rec_key, k;
	logic [15:0] rp_seq, rec_seq, cr_seq, hseq;
	logic [95:0] rp_data;
	logic [3:0] rp_len;
	logic rec_valid, rec_ready, rec_mode, cr_valid, cr_ready;
	logic [9:0] rec_instr;
	logic [6:0] rec_len;
	logic [23:0] cr_index;
	logic [63:0] cr_ad;
	logic cr_has_idx, cr_has_ad, taken;
	logic [31:0] rng, t32;
	logic [663:0] exp_rec[$];
	logic [123:0] exp_rsp[$];
	trk_s core_q[$];
	int fail_count, n_tests, cyc, tw_seen, i, j, p, r, n, d;
	logic [7:0] ops[3] = '{8'h11, 8'h12, 8'h13};
	// Full, 80-bit and short key sizes
	desc_t desc[3] = '{{10'h2A5, 2'h3, 7'h50}, {10'h0C3, 2'h1, 7'h0A},
		{10'h3FF, 2'h3, 7'h05}};
	rop_link_if lnk (.ref_clk(ref_clk));
	rop_host_end rop_host_end_inst (.ref_clk(ref_clk), .rst_b(rst_b),
		.lnk(lnk), .rq_valid(rq_valid), .rq_ready(rq_ready),
		.rq_opcode(rq_opcode), .rq_key(rq_key), .rq_last(rq_last),
		.rp_valid(rp_valid), .rp_opcode(rp_opcode), .rp_seq(rp_seq),
		.rp_error(rp_error), .rp_data(rp_data), .rp_len(rp_len));
	rop_dev_end #(.TRK_AW(4), .MAX_WORDS(8)) rop_dev_end_inst (
		.ref_clk(ref_clk), .rst_b(rst_b), .lnk(lnk), .rec_valid(rec_valid),
		.rec_ready(rec_ready), .rec_opcode(rec_opcode), .rec_seq(rec_seq),
		.rec_instr(rec_instr), .rec_mode(rec_mode), .rec_len(rec_len),
		.rec_key(rec_key), .cr_valid(cr_valid), .cr_ready(cr_ready),
		.cr_seq(cr_seq), .cr_status(cr_status), .cr_index(cr_index),
		.cr_ad(cr_ad), .cr_has_idx(cr_has_idx), .cr_has_ad(cr_has_ad));
	rop_link_chk #(.MAX_WORDS(8)) rop_link_chk_inst (.ref_clk(ref_clk),
		.rst_b(rst_b), .req_valid(lnk.req_valid), .req_ready(lnk.req_ready),
		.req_frame(lnk.req_frame), .req_data(lnk.req_data),
		.req_eop(lnk.req_eop), .rsp_valid(lnk.rsp_valid),
		.rsp_ready(lnk.rsp_ready), .rsp_frame(lnk.rsp_frame),
		.rsp_data(lnk.rsp_data), .rsp_eop(lnk.rsp_eop));
	// Clock
	always #20 ref_clk = ~ref_clk;
	function logic [31:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction
	function automatic int idx_of(logic [7:0] op);
		for (int x = 0; x < 3; x++)
			if (ops[x] == op)
				return x;
		return -1;
	endfunction
	// Reply body: status byte, then index and associated data if flagged
	function automatic logic [99:0] body_of(logic hi, logic ha,
		logic [7:0] st, logic [23:0] ix, logic [63:0] ad);
		logic [95:0] b;
		logic [3:0] m;
		b = {88'h0, hi, ha, st[5:0]};
		m = 4'h1;
		if (hi) begin
			b = {b[71:0], ix};
			m = m + 4'h3;
		end
		if (ha) begin
			b = {b[31:0], ad};
			m = m + 4'h8;
		end
		return {m, b};
	endfunction
	task cmp(input logic [639:0] got, input logic [639:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask
	task print_verdict();
		$display("Checks %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Called just after an edge; holds the record until the host takes it
	task send_req(input logic [7:0] op, input logic [639:0] kk,
		input logic last);
		int e;
		int x;
		rq_valid = 1'b1;
		rq_opcode = op;
		rq_key = kk;
		rq_last = last;
		x = 0;
		do begin
			@(posedge ref_clk);
			x++;
		end while (rq_ready !== 1'b1 && x < 2000);
		if (x >= 2000)
			fail_count++;
		#1;
		e = idx_of(op);
		if (op == 8'hFF)
			exp_rsp.push_back({8'hFF, hseq, 4'h1, 96'h0});
		else if (e >= 0)
			exp_rec.push_back({op, hseq, kk & ~({640{1'b1}} >> (int'(desc[e][6:0]) * 8))});
		hseq++;
	endtask
	// Record port monitor; taken records feed the core model
	always @(posedge ref_clk)
		if (rec_valid === 1'b1 && rec_ready === 1'b1) begin : mon_rec
			logic [663:0] e;
			int x;
			e = exp_rec.size() ? exp_rec.pop_front() : 664'h0;
			x = idx_of(e[663:656]);
			cmp(rec_opcode, e[663:656]);
			cmp(rec_seq, e[655:640]);
			cmp(rec_len, desc[x][6:0]);
			cmp(rec_instr, desc[x][18:9]);
			cmp(rec_mode, desc[x][8]);
			cmp(rec_key, e[639:0]);
			core_q.push_back('{rec_opcode, rec_seq});
		end
	// Random record stalls exercise the device's one-record output register
	always @(posedge ref_clk) begin
		#1;
		t32 = rnd();
		rec_ready = t32[1:0] != 2'h0;
	end
	// Core model: answers in request order, after a random delay
	always @(posedge ref_clk) begin
		taken = cr_valid === 1'b1 && cr_ready === 1'b1;
		if (taken) begin
			exp_rsp.push_back({core_q[0].op, cr_seq, body_of(cr_has_idx,
				cr_has_ad, cr_status, cr_index, cr_ad)});
			void'(core_q.pop_front());
		end
		#1;
		if (cr_valid !== 1'b1 || taken) begin
			t32 = rnd();
			cr_valid = core_q.size() > 0 && t32[0];
			cr_seq = core_q.size() > 0 ? core_q[0].seq : 16'h0000;
			cr_status = t32[15:8];
			cr_has_idx = t32[16];
			cr_has_ad = t32[17];
			cr_index = rnd();
			cr_ad = {rnd(), rnd()};
		end
	end
	// Reply monitor on the host side
	always @(posedge ref_clk)
		if (rp_valid === 1'b1) begin : mon_rp
			logic [123:0] e;
			e = exp_rsp.size() ? exp_rsp.pop_front() : 124'h0;
			cmp(rp_opcode, e[123:116]);
			cmp(rp_seq, e[115:100]);
			cmp(rp_len, e[99:96]);
			cmp(rp_data, e[95:0]);
			cmp(rp_error, 1'b0);
			if (rp_opcode === 8'hFF)
				tw_seen++;
		end
	// Hang guard, well above the expected few thousand cycles
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 30000) begin
			fail_count++;
			print_verdict();
		end
	end
	// Main sequence
	initial begin
		{rst_b, rq_valid, rq_last, rec_ready, cr_valid} = 5'h00;
		{cr_has_idx, cr_has_ad, rq_opcode, cr_status} = 18'h00000;
		{rq_key, cr_seq, cr_index, cr_ad} = 744'h0;
		{hseq, rng} = {16'h0000, 32'h0000004C};
		repeat (20) @(posedge ref_clk);
		#1 rst_b = 1'b1;
		// Program each entry and wait for its reply before use
		for (i = 0; i < 3; i++) begin
			send_req(8'hFF, {ops[i], 5'h00, desc[i], 608'h0}, 1'b1);
			rq_valid = 1'b0;
			for (j = 0; j < 2000 && tw_seen <= i; j++) begin
				@(posedge ref_clk);
				#1;
			end
		end
		// Random packets of one to four records, sizes mixed
		for (p = 0; p < 10; p++) begin
			n = 1 + rnd() % 4;
			for (r = 0; r < n; r++) begin
				d = rnd() % 3;
				for (j = 0; j < 20; j++)
					k = {k[607:0], rnd()};
				send_req(ops[d], k, r == n - 1);
			end
			rq_valid = 1'b0;
			repeat (rnd() % 4) begin
				@(posedge ref_clk);
				#1;
			end
		end
		// Unknown opcode ends its packet; numbering resumes after it
		send_req(8'h11, k, 1'b0);
		send_req(8'h22, k, 1'b1);
		send_req(8'h13, k, 1'b1);
		rq_valid = 1'b0;
		for (j = 0; j < 5000 && exp_rec.size() + exp_rsp.size() + core_q.size() > 0; j++)
			@(posedge ref_clk);
		cmp(exp_rec.size() + exp_rsp.size(), 0);
		print_verdict();
	end
endmodule
`default_nettype wire
